/* wdcp_defs.svh */
`ifndef WDCP_DEFS_SVH
`define WDCP_DEFS_SVH

// Register byte offsets
`define WDCP_ADDR_CTRL 12'h000
`define WDCP_ADDR_CMD 12'h004
`define WDCP_ADDR_STAT 12'h008
`define WDCP_ADDR_IRQ 12'h00C
`define WDCP_ADDR_MASK 12'h010
`define WDCP_ADDR_CYL 12'h014
`define WDCP_ADDR_MARKS 12'h018

// Control register fields
`define WDCP_CTRL_DRV 0
`define WDCP_CTRL_HEAD_LO 4
`define WDCP_CTRL_HEAD_HI 6
`define WDCP_CTRL_RWC 8
`define WDCP_CTRL_WREQ 9
`define WDCP_CTRL_STEPDIV_LO 16
`define WDCP_CTRL_STEPDIV_HI 31

// Command register fields
`define WDCP_CMD_COUNT_LO 0
`define WDCP_CMD_COUNT_HI 15
`define WDCP_CMD_OUT 16
`define WDCP_CMD_SEEK 17
`define WDCP_CMD_RECAL 18
`define WDCP_CMD_RETRY 19
`define WDCP_CMD_MARKS_LO 20
`define WDCP_CMD_MARKS_HI 27

// Interrupt status and mask bits
`define WDCP_EV_SEEKDONE 0
`define WDCP_EV_TRK0 1
`define WDCP_EV_FAULT 2
`define WDCP_EV_MARK 3
`define WDCP_EV_TIMEOUT 4
`define WDCP_EV_WIDTH 5

// Reset values
`define WDCP_CTRL_RESET 32'h0001_0000
`define WDCP_ZERO32 32'h0000_0000

// Step pulse timing
`define WDCP_STEP_PULSE_NS 10000
`define WDCP_CLK_NS 50
`define WDCP_RECAL_LIMIT 16'h0400

// AXI responses
`define WDCP_RESP_OKAY 2'b00
`define WDCP_RESP_SLVERR 2'b10

`endif

/* wdcp_pkg.sv */
package wdcp_pkg;

  typedef enum logic [1:0] {
    WDCP_IDLE,
    WDCP_SETUP,
    WDCP_PULSE,
    WDCP_GAP
  } wdcp_step_state_t;

  typedef struct packed {
    logic ready;
    logic seek_complete;
    logic track_zero;
    logic write_fault;
    logic rotation_mark;
  } wdcp_drive_in_t;

  typedef struct packed {
    logic [1:0] drive_select;
    logic [2:0] head_select;
    logic step;
    logic step_direction;
    logic write_gate;
    logic reduce_write_current;
  } wdcp_drive_out_t;

endpackage

/* wdcp_stepper.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdcp_defs.svh"

module wdcp_stepper (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request
  input wire logic start_in,
  input wire logic [15:0] count_in,
  input wire logic outward_in,
  input wire logic recal_in,
  input wire logic [15:0] gap_div_in,
  input wire logic track_zero_in,
  // Drive side
  output logic step_out,
  output logic direction_out,
  output logic busy_out,
  output logic done_out
);
  import wdcp_pkg::*;

  localparam int PULSE_CYC_I = (`WDCP_STEP_PULSE_NS + `WDCP_CLK_NS - 1) / `WDCP_CLK_NS;
  localparam logic [15:0] PULSE_CYC = PULSE_CYC_I[15:0];

  wdcp_step_state_t state;
  logic [15:0] remaining;
  logic [15:0] timer;
  logic recal;

  // ----------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= WDCP_IDLE;
      remaining <= 16'h0000;
      timer <= 16'h0000;
      recal <= 1'b0;
      step_out <= 1'b0;
      direction_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        WDCP_IDLE: begin
          if (start_in) begin
            // Direction settles a cycle ahead of the pulse
            direction_out <= recal_in ? 1'b1 : outward_in;
            remaining <= recal_in ? `WDCP_RECAL_LIMIT : count_in;
            recal <= recal_in;
            busy_out <= 1'b1;
            state <= WDCP_SETUP;
          end
        end
        WDCP_SETUP: begin
          if (remaining == 16'h0000 || (recal && track_zero_in)) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state <= WDCP_IDLE;
          end else begin
            step_out <= 1'b1;
            timer <= PULSE_CYC;
            remaining <= remaining - 16'h0001;
            state <= WDCP_PULSE;
          end
        end
        WDCP_PULSE: begin
          if (timer <= 16'h0001) begin
            step_out <= 1'b0;
            timer <= gap_div_in;
            state <= WDCP_GAP;
          end else begin
            timer <= timer - 16'h0001;
          end
        end
        WDCP_GAP: begin
          if (timer <= 16'h0001) begin
            state <= WDCP_SETUP;
          end else begin
            timer <= timer - 16'h0001;
          end
        end
        default: state <= WDCP_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* wdcp_mark_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdcp_defs.svh"

module wdcp_mark_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [7:0] limit_in,
  input wire logic rotation_mark_in,
  // Results
  output logic mark_out,
  output logic expired_out,
  output logic active_out,
  output logic [15:0] total_out
);
  import wdcp_pkg::*;

  logic mark_q;
  logic [7:0] seen;

  // ----------------------------------------------------------------
  // Rotation mark edge and retry window
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mark_q <= 1'b0;
      mark_out <= 1'b0;
      expired_out <= 1'b0;
      active_out <= 1'b0;
      seen <= 8'h00;
      total_out <= 16'h0000;
    end else begin
      mark_q <= rotation_mark_in;
      mark_out <= rotation_mark_in && !mark_q;
      expired_out <= 1'b0;
      if (rotation_mark_in && !mark_q) begin
        total_out <= total_out + 16'h0001;
      end
      if (start_in) begin
        active_out <= 1'b1;
        seen <= 8'h00;
      end else if (stop_in) begin
        active_out <= 1'b0;
      end else if (active_out && rotation_mark_in && !mark_q) begin
        if (seen + 8'h01 >= limit_in) begin
          active_out <= 1'b0;
          expired_out <= 1'b1;
        end
        seen <= seen + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

/* wdcp_top.sv */
// Summary of operation
// - Reduce write current only asserted together with write gate.
// - Head select lines carry binary number of active head.
// - Write gate only enables writing; held low and glitch free from reset.
// - Rotation mark serves as track reference point when formatting.
// - Rotation marks are counted to time out retries.
// - One step pulse per single cylinder move.
// - Step direction one moves out, zero moves in.
// - Two drive select bits choose first or second drive.
// - Serial data uses a dedicated cable pair per drive.
`timescale 1ns/1ps
`default_nettype none
`include "wdcp_defs.svh"

module wdcp_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Drive control bus
  input wire wdcp_pkg::wdcp_drive_in_t drive_in,
  output wdcp_pkg::wdcp_drive_out_t drive_out,
  // Serial data, one pair per drive
  input wire logic mfm_write_data_in,
  output logic [1:0] mfm_write_data_out,
  input wire logic [1:0] mfm_read_data_in,
  output logic mfm_read_data_out,
  // Interrupt
  output logic irq_out
);
  import wdcp_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] cmd;
  logic [`WDCP_EV_WIDTH-1:0] irq_stat;
  logic [`WDCP_EV_WIDTH-1:0] irq_mask;
  logic [15:0] cylinder;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_fire;
  logic step_start;
  logic step_busy;
  logic timer_stop;
  logic step_pulse;
  logic step_dir;
  logic step_dir_raw;
  logic timer_start;
  logic mark_ev;
  logic timeout_ev;
  logic timer_active;
  logic [15:0] mark_total;
  logic seek_q;
  logic trk0_q;
  logic fault_q;
  logic [`WDCP_EV_WIDTH-1:0] events;
  logic write_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign write_ok = drive_in.ready && drive_in.seek_complete && !drive_in.write_fault;

  // ----------------------------------------------------------------
  // AXI write path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDCP_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= `WDCP_ZERO32;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `WDCP_ADDR_CTRL || aw_addr == `WDCP_ADDR_CMD ||
            aw_addr == `WDCP_ADDR_IRQ || aw_addr == `WDCP_ADDR_MASK) begin
          s_axi_bresp <= `WDCP_RESP_OKAY;
        end else if (aw_addr == `WDCP_ADDR_STAT || aw_addr == `WDCP_ADDR_CYL ||
                     aw_addr == `WDCP_ADDR_MARKS) begin
          s_axi_bresp <= `WDCP_RESP_OKAY;
        end else begin
          s_axi_bresp <= `WDCP_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, command and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `WDCP_CTRL_RESET;
      cmd <= `WDCP_ZERO32;
      irq_mask <= '0;
      step_start <= 1'b0;
      timer_start <= 1'b0;
      timer_stop <= 1'b0;
    end else begin
      step_start <= 1'b0;
      timer_start <= 1'b0;
      timer_stop <= 1'b0;
      if (wr_fire) begin
        if (aw_addr == `WDCP_ADDR_CTRL) begin
          ctrl <= merge(ctrl, w_data, w_strb);
        end else if (aw_addr == `WDCP_ADDR_CMD) begin
          cmd <= merge(cmd, w_data, w_strb);
          step_start <= !step_busy && (w_data[`WDCP_CMD_SEEK] || w_data[`WDCP_CMD_RECAL]);
          timer_start <= w_data[`WDCP_CMD_RETRY];
          // Retry bit clear with a zero limit cancels the window
          timer_stop <= !w_data[`WDCP_CMD_RETRY] && w_data[`WDCP_CMD_MARKS_HI:`WDCP_CMD_MARKS_LO] == 8'h00;
        end else if (aw_addr == `WDCP_ADDR_MASK) begin
          irq_mask <= w_data[`WDCP_EV_WIDTH-1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Head position tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      step_dir <= 1'b0;
      cylinder <= 16'h0000;
    end else begin
      step_dir <= step_pulse;
      if (step_pulse && !step_dir) begin
        if (drive_out.step_direction) begin
          cylinder <= (cylinder == 16'h0000) ? 16'h0000 : cylinder - 16'h0001;
        end else begin
          cylinder <= cylinder + 16'h0001;
        end
      end
      if (drive_in.track_zero) begin
        cylinder <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[`WDCP_EV_SEEKDONE] = drive_in.seek_complete && !seek_q;
    events[`WDCP_EV_TRK0] = drive_in.track_zero && !trk0_q;
    events[`WDCP_EV_FAULT] = drive_in.write_fault && !fault_q;
    events[`WDCP_EV_MARK] = mark_ev;
    events[`WDCP_EV_TIMEOUT] = timeout_ev;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      seek_q <= 1'b0;
      trk0_q <= 1'b0;
      fault_q <= 1'b0;
      irq_stat <= '0;
      irq_out <= 1'b0;
    end else begin
      seek_q <= drive_in.seek_complete;
      trk0_q <= drive_in.track_zero;
      fault_q <= drive_in.write_fault;
      // Set beats a same-cycle clear
      if (wr_fire && aw_addr == `WDCP_ADDR_IRQ) begin
        irq_stat <= (irq_stat & ~w_data[`WDCP_EV_WIDTH-1:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
      irq_out <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      drive_out <= '0;
    end else begin
      drive_out.drive_select <= ctrl[`WDCP_CTRL_DRV] ? 2'b10 : 2'b01;
      drive_out.head_select <= ctrl[`WDCP_CTRL_HEAD_HI:`WDCP_CTRL_HEAD_LO];
      drive_out.step <= step_pulse;
      drive_out.step_direction <= step_dir_raw;
      drive_out.write_gate <= ctrl[`WDCP_CTRL_WREQ] && write_ok && !step_busy;
      drive_out.reduce_write_current <= ctrl[`WDCP_CTRL_RWC] && ctrl[`WDCP_CTRL_WREQ] &&
                                        write_ok && !step_busy;
    end
  end

  // ----------------------------------------------------------------
  // Serial data routed to the selected drive only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mfm_write_data_out <= 2'b00;
      mfm_read_data_out <= 1'b0;
    end else begin
      mfm_write_data_out[0] <= !ctrl[`WDCP_CTRL_DRV] && drive_out.write_gate && mfm_write_data_in;
      mfm_write_data_out[1] <= ctrl[`WDCP_CTRL_DRV] && drive_out.write_gate && mfm_write_data_in;
      mfm_read_data_out <= mfm_read_data_in[ctrl[`WDCP_CTRL_DRV]];
    end
  end

  // ----------------------------------------------------------------
  // AXI read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `WDCP_ZERO32;
      s_axi_rresp <= `WDCP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `WDCP_RESP_OKAY;
        s_axi_rdata <= `WDCP_ZERO32;
        if (s_axi_araddr == `WDCP_ADDR_CTRL) begin
          s_axi_rdata <= ctrl;
        end else if (s_axi_araddr == `WDCP_ADDR_CMD) begin
          s_axi_rdata <= cmd;
        end else if (s_axi_araddr == `WDCP_ADDR_STAT) begin
          s_axi_rdata <= {24'h00_0000, timer_active, step_busy, drive_out.write_gate,
                          drive_in.rotation_mark, drive_in.write_fault, drive_in.track_zero,
                          drive_in.seek_complete, drive_in.ready};
        end else if (s_axi_araddr == `WDCP_ADDR_IRQ) begin
          s_axi_rdata[`WDCP_EV_WIDTH-1:0] <= irq_stat;
        end else if (s_axi_araddr == `WDCP_ADDR_MASK) begin
          s_axi_rdata[`WDCP_EV_WIDTH-1:0] <= irq_mask;
        end else if (s_axi_araddr == `WDCP_ADDR_CYL) begin
          s_axi_rdata[15:0] <= cylinder;
        end else if (s_axi_araddr == `WDCP_ADDR_MARKS) begin
          s_axi_rdata[15:0] <= mark_total;
        end else begin
          s_axi_rresp <= `WDCP_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------

  wdcp_stepper u_stepper (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(step_start),
    .count_in(w_data[`WDCP_CMD_COUNT_HI:`WDCP_CMD_COUNT_LO]),
    .outward_in(w_data[`WDCP_CMD_OUT]),
    .recal_in(w_data[`WDCP_CMD_RECAL]),
    .gap_div_in(ctrl[`WDCP_CTRL_STEPDIV_HI:`WDCP_CTRL_STEPDIV_LO]),
    .track_zero_in(drive_in.track_zero),
    .step_out(step_pulse),
    .direction_out(step_dir_raw),
    .busy_out(step_busy),
    .done_out()
  );

  wdcp_mark_timer u_marks (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(timer_start),
    .stop_in(timer_stop),
    .limit_in(cmd[`WDCP_CMD_MARKS_HI:`WDCP_CMD_MARKS_LO]),
    .rotation_mark_in(drive_in.rotation_mark),
    .mark_out(mark_ev),
    .expired_out(timeout_ev),
    .active_out(timer_active),
    .total_out(mark_total)
  );

endmodule

`default_nettype wire

/* wdcp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module wdcp_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Observed ports
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire wdcp_pkg::wdcp_drive_in_t drive_in,
  input wire wdcp_pkg::wdcp_drive_out_t drive_out,
  input wire logic [1:0] mfm_write_data_out
);
  import wdcp_pkg::*;
  localparam int STEP_CYC = 200;
  int hi_cnt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ----------
  // Step high time
  // ----------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= drive_out.step ? hi_cnt + 1 : 0;
    end
  end
  sequence step_end_s;
    $fell(drive_out.step);
  endsequence
  sequence resp_wait_s;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  rwc_gate_a: assert property (drive_out.reduce_write_current |-> drive_out.write_gate)
    else $error("reduce current without write gate");
  wg_drive_a: assert property (drive_out.write_gate |->
    $past(drive_in.ready && drive_in.seek_complete && !drive_in.write_fault))
    else $error("write gate without healthy drive");
  wg_step_a: assert property (drive_out.step |-> !drive_out.write_gate)
    else $error("write gate while stepping");
  dir_hold_a: assert property (drive_out.step |-> $stable(drive_out.step_direction))
    else $error("direction moved during step");
  drv_sel_a: assert property (drive_out.drive_select != 2'h3)
    else $error("both drives selected");
  mfm_lane_a: assert property ($stable(drive_out.drive_select) |->
    (mfm_write_data_out & ~drive_out.drive_select) == 2'h0)
    else $error("write data on unselected lane");
  step_width_a: assert property (step_end_s |-> hi_cnt == STEP_CYC)
    else $error("step pulse width wrong");
  resp_hold_a: assert property (resp_wait_s |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind wdcp_top wdcp_chk i_chk (.clk_in, .nrst_in, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .drive_in, .drive_out, .mfm_write_data_out);
`default_nettype wire

/* wdcp_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wdcp_drive_model #(
  parameter int REV = 400,
  parameter int SETTLE = 20
) (
  // Clock and fault request
  input wire logic clk_in,
  input wire logic fault_in,
  // Control cable
  input wire wdcp_pkg::wdcp_drive_out_t drv_in,
  output wdcp_pkg::wdcp_drive_in_t drv_out,
  // Radial data and step tally
  output logic [1:0] read_data_out,
  output int steps_out
);
  import wdcp_pkg::*;
  int cyl[2] = '{3, 3};
  int rev_cnt = 0;
  int settle = 0;
  int spin = 0;
  int n_steps = 0;
  logic prev_step = 0;
  logic sel;
  logic valid;
  assign sel = drv_in.drive_select[1];
  assign valid = ^drv_in.drive_select;
  assign steps_out = n_steps;
  always @(posedge clk_in) begin
    prev_step <= drv_in.step;
    rev_cnt <= (rev_cnt + 1) % REV;
    if (spin < 50) spin <= spin + 1;
    if (settle != 0) settle <= settle - 1;
    if (drv_in.step && !prev_step) begin
      n_steps <= n_steps + 1;
      settle <= SETTLE;
      if (drv_in.step_direction) cyl[sel] <= (cyl[sel] > 0) ? cyl[sel] - 1 : 0;
      else cyl[sel] <= cyl[sel] + 1;
    end
  end
  always_comb begin
    drv_out.ready = valid && spin == 50;
    drv_out.seek_complete = valid && settle == 0 && !drv_in.step;
    drv_out.track_zero = valid && cyl[sel] == 0;
    drv_out.write_fault = valid && fault_in;
    drv_out.rotation_mark = rev_cnt < 2;
  end
  // Own pattern per drive, changing each cycle
  assign read_data_out = {rev_cnt[0], ~rev_cnt[0]};
endmodule
`default_nettype wire

/* wdcp_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module wdcp_top_test;
  import wdcp_pkg::*;
  localparam int REV = 400;
  logic clk_in = 0, nrst_in = 0, mfm_write_data_in = 0, fault_in = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_out, mfm_read_data_out, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, mfm_write_data_out, mfm_read_data_in, r;
  logic [2:0] h;
  wdcp_drive_in_t drive_in;
  wdcp_drive_out_t drive_out;
  int err_total = 0, cmp_count = 0, steps, ec = 3;
  wdcp_top i_dut (.clk_in, .nrst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .drive_in, .drive_out, .mfm_write_data_in, .mfm_write_data_out,
    .mfm_read_data_in, .mfm_read_data_out, .irq_out);
  wdcp_drive_model #(.REV(REV)) i_drv (.clk_in, .fault_in, .drv_in(drive_out), .drv_out(drive_in),
    .read_data_out(mfm_read_data_in), .steps_out(steps));
  // ----------
  // Tasks
  // ----------
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    bit b, aw, w, ar;
    n = 0;
    b = 0;
    @(posedge clk_in);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
    end
    while (!b && n < 100) begin
      @(negedge clk_in);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      b = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_in);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (ar) s_axi_arvalid <= 0;
      if (b) s_axi_bready <= 0;
      if (b) s_axi_rready <= 0;
      n++;
    end
    if (!b) err_total++;
  endtask
  task automatic steps_wait(input logic dir, input int n);
    int s0, quiet, bad;
    s0 = steps;
    quiet = 0;
    bad = 0;
    while (quiet < 400) begin
      @(negedge clk_in);
      quiet = drive_out.step ? 0 : quiet + 1;
      if (drive_out.step && drive_out.step_direction !== dir) bad = 1;
    end
    check("step count", steps - s0, n);
    check("step direction", bad, 0);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    test_done;
  end
  initial begin
    void'($urandom(32'h0000_8813));
    repeat (4) @(posedge clk_in);
    nrst_in <= 1;
    repeat (4) @(posedge clk_in);
    axi(0, 12'h000, 0);
    check("ctrl reset", q, 32'h0001_0000);
    axi(0, 12'h01C, 0);
    check("unmapped resp", r, 2'h2);
    check("unmapped data", q, 0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      h = 3'($urandom);
      axi(1, 12'h000, {16'h0001, 9'h000, h, 3'h0, i[0]});
      repeat (3) @(negedge clk_in);
      check("drive select", drive_out.drive_select, i[0] ? 2'h2 : 2'h1);
      check("head select", drive_out.head_select, h);
    end
    $display("test select done");
    axi(1, 12'h004, 32'h0002_0002);
    ec += 2;
    steps_wait(0, 2);
    axi(1, 12'h004, 32'h0003_0001);
    ec -= 1;
    steps_wait(1, 1);
    axi(1, 12'h004, 32'h0004_0000);
    steps_wait(1, ec);
    axi(0, 12'h008, 0);
    check("track zero", q[2], 1);
    axi(0, 12'h014, 0);
    check("cylinder", q, 0);
    $display("test step done");
    axi(1, 12'h000, 32'h0001_0301);
    @(posedge clk_in);
    mfm_write_data_in <= 1;
    repeat (3) @(negedge clk_in);
    check("write gate", drive_out.write_gate, 1);
    check("reduce current", drive_out.reduce_write_current, 1);
    check("write lane", mfm_write_data_out, 2'h2);
    rd = mfm_read_data_in[1];
    @(negedge clk_in);
    check("read lane", mfm_read_data_out, rd);
    axi(1, 12'h010, 32'h0000_0004);
    @(posedge clk_in);
    fault_in <= 1;
    repeat (4) @(negedge clk_in);
    check("gate on fault", drive_out.write_gate, 0);
    check("fault irq", irq_out, 1);
    @(posedge clk_in);
    fault_in <= 0;
    axi(1, 12'h00C, 32'h0000_0004);
    repeat (3) @(negedge clk_in);
    check("irq cleared", irq_out, 0);
    $display("test write done");
    axi(1, 12'h00C, 32'h0000_001F);
    axi(1, 12'h010, 32'h0000_0010);
    axi(1, 12'h004, 32'h0028_0000);
    repeat (REV) @(negedge clk_in);
    check("timer early", irq_out, 0);
    repeat (2 * REV) @(negedge clk_in);
    check("timer expired", irq_out, 1);
    $display("test timer done");
    test_done;
  end
endmodule
`default_nettype wire
